// ==== sppl_pkg.sv ====
package sppl_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [13:0] IDX_REMAP2   = 14'h1857;
	localparam logic [13:0] IDX_FAIL0    = 14'h1858;
	localparam logic [13:0] IDX_FAIL1    = 14'h1859;
	localparam logic [13:0] IDX_FAIL2    = 14'h185A;
	localparam logic [13:0] IDX_MASK     = 14'h1880;
	localparam logic [13:0] IDX_PENDING  = 14'h1881;
	localparam logic [13:0] IDX_EVT_STAT = 14'h1890;
	localparam logic [13:0] IDX_EVT_MASK = 14'h1891;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int          PRIO_W      = 3;
	localparam int          NUM_PRIO    = 8;
	localparam int          REMAP_W     = 24;
	localparam int          NUM_PORTS   = 3;
	localparam int          ADDR_LSB    = 2;
	localparam int          ADDR_W      = 16;
	localparam int          MASK_BIT    = 0;
	localparam logic [23:0] REMAP_RST   = 24'hFA_C688;
	localparam logic [31:0] CNT_MAX     = 32'hFFFF_FFFF;
	localparam logic [31:0] CNT_ZERO    = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE     = 32'h0000_0001;
	localparam logic        MASK_RST    = 1'b1;
	localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

	// event status bits: [0..2] counter saturated per port
	localparam int          EVT_W       = 3;

	typedef enum logic [1:0] {
		SPPL_IDLE = 2'b00,
		SPPL_ACK  = 2'b01
	} sppl_bus_t;

endpackage

// ==== sppl_regs.sv ====
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// (R1) port 2 priority translated through table
// (R2) eight 3-bit entries, entry 7 on top
// (R3) entries reset to their own index
// (R4) count unlearned addresses per port
// (R5) 32-bit counters, reset zero, clear-on-read
// (R6) counters saturate at all ones
// (R7) mask bit 0 blocks engine interrupt
// (R8) mask resets set
// (R9) mask gates output only, pending kept
// (R10) reserved bits read zero, ignore writes
module sppl_regs (
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [15:0]                 wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic                        rx_prio_valid,
	input  wire logic [2:0]                  rx_prio,
	output logic                             queue_prio_valid,
	output logic      [2:0]                  queue_prio,
	input  wire logic [2:0]                  learn_fail,
	input  wire logic                        engine_irq_pending,
	output logic                             switch_irq,
	output logic                             sppl_irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [23:0]         remap_r,   remap_nxt;
	logic [31:0]         cnt_r [3], cnt_nxt [3];
	logic                mask_r,    mask_nxt;
	logic [2:0]          evt_r,     evt_nxt;
	logic [2:0]          emask_r,   emask_nxt;
	logic                ack_r,     ack_nxt;
	logic [31:0]         rdat_r,    rdat_nxt;
	logic                qv_r,      qv_nxt;
	logic [2:0]          qp_r,      qp_nxt;
	logic                sirq_r,    sirq_nxt;
	logic                birq_r,    birq_nxt;
	logic                req;
	logic                wr;
	logic                rd;
	logic [13:0]         idx;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [2:0] entry(input logic [23:0] t,
		input logic [2:0] p);
		return t[p*sppl_pkg::PRIO_W +: sppl_pkg::PRIO_W];
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr  = req && wb_we_i;
	assign rd  = req && !wb_we_i;
	assign idx = wb_adr_i[15:sppl_pkg::ADDR_LSB];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] m;
		m         = 32'h0000_0000;
		remap_nxt = remap_r;
		mask_nxt  = mask_r;
		emask_nxt = emask_r;
		evt_nxt   = evt_r;
		ack_nxt   = req;
		rdat_nxt  = rdat_r;
		for (int p = 0; p < sppl_pkg::NUM_PORTS; p++) begin
			cnt_nxt[p] = cnt_r[p];
		end
		if (rd) begin
			case (idx)
				sppl_pkg::IDX_REMAP2:   rdat_nxt = {8'h00, remap_r};
				sppl_pkg::IDX_FAIL0:    rdat_nxt = cnt_r[0];
				sppl_pkg::IDX_FAIL1:    rdat_nxt = cnt_r[1];
				sppl_pkg::IDX_FAIL2:    rdat_nxt = cnt_r[2];
				sppl_pkg::IDX_MASK:     rdat_nxt = {31'h0, mask_r};
				sppl_pkg::IDX_PENDING:
					rdat_nxt = {31'h0, engine_irq_pending};
				sppl_pkg::IDX_EVT_STAT: rdat_nxt = {29'h0, evt_r};
				sppl_pkg::IDX_EVT_MASK: rdat_nxt = {29'h0, emask_r};
				default:                rdat_nxt = sppl_pkg::UNMAPPED_RD;
			endcase
		end
		if (wr) begin
			case (idx)
				// (R10) reserved bits dropped
				sppl_pkg::IDX_REMAP2: begin
					m         = merge({8'h00, remap_r}, wb_dat_i, wb_sel_i);
					remap_nxt = m[sppl_pkg::REMAP_W-1:0];
				end
				sppl_pkg::IDX_MASK: begin
					if (wb_sel_i[0]) begin
						mask_nxt = wb_dat_i[sppl_pkg::MASK_BIT];
					end
				end
				sppl_pkg::IDX_EVT_STAT: begin
					if (wb_sel_i[0]) begin
						evt_nxt = evt_r & ~wb_dat_i[sppl_pkg::EVT_W-1:0];
					end
				end
				sppl_pkg::IDX_EVT_MASK: begin
					if (wb_sel_i[0]) begin
						emask_nxt = wb_dat_i[sppl_pkg::EVT_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		for (int p = 0; p < sppl_pkg::NUM_PORTS; p++) begin
			// (R5) clear on read, then count
			if (rd && idx == sppl_pkg::IDX_FAIL0 + 14'(p)) begin
				cnt_nxt[p] = sppl_pkg::CNT_ZERO;
			end
			// (R4) count failures; (R6) hold at max
			if (learn_fail[p]) begin
				if (cnt_nxt[p] != sppl_pkg::CNT_MAX) begin
					cnt_nxt[p] = cnt_nxt[p] + sppl_pkg::CNT_ONE;
				end
				if (cnt_nxt[p] == sppl_pkg::CNT_MAX) begin
					evt_nxt[p] = 1'b1;
				end
			end
		end
		// (R1) translate port 2 priority
		qv_nxt   = rx_prio_valid;
		qp_nxt   = entry(remap_r, rx_prio);
		// (R7) mask gates; (R9) pending untouched
		sirq_nxt = engine_irq_pending && !mask_r;
		birq_nxt = |(evt_nxt & emask_nxt);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// (R2) (R3) identity table
			remap_r <= sppl_pkg::REMAP_RST;
			for (int p = 0; p < sppl_pkg::NUM_PORTS; p++) begin
				cnt_r[p] <= sppl_pkg::CNT_ZERO;
			end
			// (R8) mask set at reset
			mask_r  <= sppl_pkg::MASK_RST;
			evt_r   <= 3'h0;
			emask_r <= 3'h0;
			ack_r   <= 1'b0;
			rdat_r  <= sppl_pkg::UNMAPPED_RD;
			qv_r    <= 1'b0;
			qp_r    <= 3'h0;
			sirq_r  <= 1'b0;
			birq_r  <= 1'b0;
		end else begin
			remap_r <= remap_nxt;
			for (int p = 0; p < sppl_pkg::NUM_PORTS; p++) begin
				cnt_r[p] <= cnt_nxt[p];
			end
			mask_r  <= mask_nxt;
			evt_r   <= evt_nxt;
			emask_r <= emask_nxt;
			ack_r   <= ack_nxt;
			rdat_r  <= rdat_nxt;
			qv_r    <= qv_nxt;
			qp_r    <= qp_nxt;
			sirq_r  <= sirq_nxt;
			birq_r  <= birq_nxt;
		end
	end

	assign wb_dat_o         = rdat_r;
	assign wb_ack_o         = ack_r;
	assign queue_prio_valid = qv_r;
	assign queue_prio       = qp_r;
	assign switch_irq       = sirq_r;
	assign sppl_irq         = birq_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_prio_translate: assert property ( // (R1)
		@(posedge clock) disable iff (!rst_n)
		rx_prio_valid |=> queue_prio_valid &&
			queue_prio == entry($past(remap_r), $past(rx_prio)))
		else $error("priority not translated");

	chk_remap_reset: assert property ( // (R3)
		@(posedge clock) disable iff (!rst_n)
		$rose(rst_n) |-> remap_r == sppl_pkg::REMAP_RST)
		else $error("remap not identity after reset");

	chk_entry_top: assert property ( // (R2)
		@(posedge clock) disable iff (!rst_n)
		wr && idx == sppl_pkg::IDX_REMAP2 && wb_sel_i[2]
		|=> entry(remap_r, 3'd7) == $past(wb_dat_i[23:21]))
		else $error("entry 7 misplaced");

	chk_count_inc: assert property ( // (R4)
		@(posedge clock) disable iff (!rst_n)
		learn_fail[0] && !(rd && idx == sppl_pkg::IDX_FAIL0)
		&& cnt_r[0] != sppl_pkg::CNT_MAX
		|=> cnt_r[0] == $past(cnt_r[0]) + sppl_pkg::CNT_ONE)
		else $error("port 0 count missed");

	chk_read_clear: assert property ( // (R5)
		@(posedge clock) disable iff (!rst_n)
		rd && idx == sppl_pkg::IDX_FAIL1 && !learn_fail[1]
		|=> cnt_r[1] == 32'h0000_0000 && wb_ack_o
		&& wb_dat_o == $past(cnt_r[1]))
		else $error("read did not clear");

	chk_count_sat: assert property ( // (R6)
		@(posedge clock) disable iff (!rst_n)
		cnt_r[2] == sppl_pkg::CNT_MAX
		&& !(rd && idx == sppl_pkg::IDX_FAIL2)
		|=> cnt_r[2] == sppl_pkg::CNT_MAX)
		else $error("counter wrapped");

	chk_mask_gate: assert property ( // (R7)
		@(posedge clock) disable iff (!rst_n)
		mask_r |=> !switch_irq)
		else $error("masked interrupt leaked");

	chk_unmask_pass: assert property ( // (R7)
		@(posedge clock) disable iff (!rst_n)
		!mask_r && engine_irq_pending |=> switch_irq)
		else $error("pending interrupt not passed");

	chk_mask_reset: assert property ( // (R8)
		@(posedge clock) disable iff (!rst_n)
		$rose(rst_n) |-> mask_r)
		else $error("mask clear after reset");

	chk_rsvd_zero: assert property ( // (R10)
		@(posedge clock) disable iff (!rst_n)
		rd && idx == sppl_pkg::IDX_MASK |=> wb_dat_o[31:1] == 31'h0)
		else $error("reserved bits nonzero");

	chk_remap_rsvd: assert property ( // (R10)
		@(posedge clock) disable iff (!rst_n)
		rd && idx == sppl_pkg::IDX_REMAP2 |=> wb_dat_o[31:24] == 8'h00)
		else $error("remap reserved bits nonzero");

	chk_pending_report: assert property ( // (R9)
		@(posedge clock) disable iff (!rst_n)
		rd && idx == sppl_pkg::IDX_PENDING
		|=> wb_dat_o == {31'h0, $past(engine_irq_pending)})
		else $error("pending not reported");

	chk_clear_count: assert property ( // (R5)
		@(posedge clock) disable iff (!rst_n)
		rd && idx == sppl_pkg::IDX_FAIL2 && learn_fail[2]
		|=> cnt_r[2] == sppl_pkg::CNT_ONE)
		else $error("event lost at read clear");

	chk_count_idle: assert property ( // (R4)
		@(posedge clock) disable iff (!rst_n)
		!learn_fail[1] && !(rd && idx == sppl_pkg::IDX_FAIL1)
		|=> $stable(cnt_r[1]))
		else $error("count moved without event");

	chk_valid_follow: assert property ( // (R1)
		@(posedge clock) disable iff (!rst_n)
		!rx_prio_valid |=> !queue_prio_valid)
		else $error("spurious queue priority");

	chk_remap_hold: assert property ( // (R2)
		@(posedge clock) disable iff (!rst_n)
		!(wr && idx == sppl_pkg::IDX_REMAP2) |=> $stable(remap_r))
		else $error("remap changed without write");

	chk_mask_write: assert property ( // (R7)
		@(posedge clock) disable iff (!rst_n)
		wr && idx == sppl_pkg::IDX_MASK && wb_sel_i[0]
		|=> mask_r == $past(wb_dat_i[sppl_pkg::MASK_BIT]))
		else $error("mask write lost");

	chk_sat_event: assert property ( // (R6)
		@(posedge clock) disable iff (!rst_n)
		learn_fail[0] && cnt_r[0] == sppl_pkg::CNT_MAX
		&& !(rd && idx == sppl_pkg::IDX_FAIL0)
		|=> evt_r[0])
		else $error("saturation event missed");

endmodule

// ==== sppl_regs_bench.sv ====
`timescale 1ns/1ps
module sppl_regs_bench;
	logic        clock;
	logic        rst_n;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [15:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        rx_prio_valid;
	logic [2:0]  rx_prio;
	logic        queue_prio_valid;
	logic [2:0]  queue_prio;
	logic [2:0]  learn_fail;
	logic        engine_irq_pending;
	logic        switch_irq;
	logic        sppl_irq;
	int          mismatches;
	int          compares;
	int          cycles;
	logic [31:0] seed;
	logic [31:0] tbl;
	logic [31:0] q;
	logic [31:0] v;
	int          cnt [3];

	sppl_regs i_sppl_regs (.clock(clock), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rx_prio_valid(rx_prio_valid), .rx_prio(rx_prio),
		.queue_prio_valid(queue_prio_valid), .queue_prio(queue_prio),
		.learn_fail(learn_fail), .engine_irq_pending(engine_irq_pending),
		.switch_irq(switch_irq), .sppl_irq(sppl_irq));

	// ----------------------------------------------------------------
	// clock and timeout
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [2:0] ident_of(input int p);
		return 3'(p);
	endfunction

	function automatic logic [31:0] ident_tbl();
		logic [31:0] t;
		t = 32'h0000_0000;
		for (int p = 0; p < 8; p++) t[3*p +: 3] = ident_of(p);
		return t;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic we, input logic [13:0] idx,
			input logic [3:0] sel, input logic [31:0] d);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 4'hF, 32'h0000_0000);
		chk(q, exp);
	endtask

	task automatic prio(input logic [2:0] p, input logic [2:0] e);
		@(posedge clock);
		rx_prio_valid <= 1'b1;
		rx_prio       <= p;
		@(posedge clock);
		rx_prio_valid <= 1'b0;
		#1;
		chk({28'h0000_000, queue_prio_valid, queue_prio}, {28'h0, 1'b1, e});
	endtask

	task automatic end_of_test();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, rx_prio_valid} = 4'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{rx_prio, learn_fail, engine_irq_pending} = '0;
		{mismatches, compares, cycles} = '0;
		seed = 32'hbbfd_9726;
		rst_n = 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		tbl = ident_tbl();
		rd(sppl_pkg::IDX_REMAP2, tbl);
		for (int p = 0; p < 3; p++) rd(sppl_pkg::IDX_FAIL0 + 14'(p), 0);
		rd(sppl_pkg::IDX_MASK, 32'h0000_0001);
		rd(14'h0040, 32'h0000_0000);
		for (int p = 0; p < 8; p++) prio(3'(p), ident_of(p));
		repeat (4) begin
			v = xs();
			bus(1'b1, sppl_pkg::IDX_REMAP2, 4'hF, v);
			tbl = {8'h00, v[23:0]};
			rd(sppl_pkg::IDX_REMAP2, tbl);
			for (int p = 0; p < 8; p++) prio(3'(p), tbl[3*p +: 3]);
		end
		bus(1'b1, sppl_pkg::IDX_REMAP2, 4'h2, 32'h0000_0000);
		rd(sppl_pkg::IDX_REMAP2, tbl & 32'hFFFF_00FF);
		cnt = '{0, 0, 0};
		for (int i = 0; i < 300; i++) begin
			v = xs();
			@(posedge clock);
			learn_fail <= v[2:0];
			for (int p = 0; p < 3; p++) cnt[p] += int'(v[p]);
		end
		@(posedge clock);
		learn_fail <= 3'h0;
		for (int p = 0; p < 3; p++) begin
			rd(sppl_pkg::IDX_FAIL0 + 14'(p), 32'(cnt[p]));
			rd(sppl_pkg::IDX_FAIL0 + 14'(p), 32'h0000_0000);
		end
		fork
			bus(1'b0, sppl_pkg::IDX_FAIL2, 4'hF, 32'h0000_0000);
			begin
				@(posedge clock);
				learn_fail <= 3'h4;
				@(posedge clock);
				learn_fail <= 3'h0;
			end
		join
		chk(q, 32'h0000_0000);
		rd(sppl_pkg::IDX_FAIL2, 32'h0000_0001);
		@(posedge clock);
		engine_irq_pending <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk({31'h0, switch_irq}, 32'h0000_0000);
		bus(1'b1, sppl_pkg::IDX_MASK, 4'hF, 32'hFFFF_FFFE);
		rd(sppl_pkg::IDX_MASK, 32'h0000_0000);
		#1;
		chk({31'h0, switch_irq}, 32'h0000_0001);
		bus(1'b1, sppl_pkg::IDX_MASK, 4'hF, 32'h0000_0001);
		rd(sppl_pkg::IDX_PENDING, 32'h0000_0001);
		#1;
		chk({31'h0, switch_irq}, 32'h0000_0000);
		bus(1'b1, sppl_pkg::IDX_EVT_MASK, 4'hF, 32'hFFFF_FFFF);
		rd(sppl_pkg::IDX_EVT_MASK, 32'h0000_0007);
		rd(sppl_pkg::IDX_EVT_STAT, 32'h0000_0000);
		bus(1'b1, sppl_pkg::IDX_EVT_STAT, 4'hF, 32'hFFFF_FFFF);
		#1;
		chk({31'h0, sppl_irq}, 32'h0000_0000);
		@(posedge clock);
		learn_fail <= 3'h4;
		@(posedge clock);
		learn_fail <= 3'h0;
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd(sppl_pkg::IDX_REMAP2, ident_tbl());
		rd(sppl_pkg::IDX_MASK, 32'h0000_0001);
		rd(sppl_pkg::IDX_FAIL2, 32'h0000_0000);
		#1;
		chk({31'h0, switch_irq}, 32'h0000_0000);
		end_of_test();
	end
endmodule
